// *** rtl/accel_sample_fifo.v ***
// Three-axis sample buffer with mode control, watermark, overflow and range setup.
// Assumes a register port on ref_clk, event pulses on ref_clk, sample data on ref_clk.
//
// Functional notes
// - Mode code 00 off, 01 circular, 10 stop when full, 11 trigger.
// - Circular mode drops oldest sample when full and stores the new one.
// - Stop mode refuses samples once full, contents kept.
// - Buffer empties on disable, auto rate change and standby-to-active.
// - Writing mode off clears overflow, watermark and count.
// - Overflow flag set when count reaches 32.
// - Watermark flag high while count is at or above watermark field.
// - Watermark field zero never raises the watermark flag.
// - In trigger mode watermark field only drives the watermark flag; it does not limit pre-trigger samples kept.
// - Count above watermark never stops acceptance by itself.
// - Mode writable when active; watermark written only in standby.
// - One sample per rate period, active or sleep rate selected.
// - Data read returns oldest sample, pops it, count decrements.
// - Short burst drops unread axes; next read starts at next X.
// - Trigger mode overwrites until trigger, then fills and drops newest.
// - Buffer holds 32 samples of X, Y and Z.
// - High-pass select one gives filtered data, zero bypasses filter.
// - Range code 00 2g, 01 4g, 10 8g, 11 reserved.
// - Buffer on: X high address reads head, other axis addresses zero.
// - Sleep hold gate keeps contents, flags error, blocks until emptied.
`timescale 1ns/10ps
`include "accel_fifo_defines.vh"
module accel_sample_fifo #(
    parameter DW    = 14,
    parameter DEPTH = `BUF_DEPTH,
    parameter AW    = 5,
    parameter CW    = 20
) (
    input  wire          ref_clk,
    input  wire          rst,
    // Register port.
    input  wire [7:0]    reg_addr,
    input  wire          reg_wr,
    input  wire [7:0]    reg_wdata,
    input  wire          reg_rd,
    input  wire          burst_end,
    output reg  [7:0]    reg_rdata,
    // System state.
    input  wire          active,
    input  wire          sleeping,
    input  wire          sleep_hold_gate,
    input  wire [CW-1:0] active_output_rate,
    input  wire [CW-1:0] sleep_output_rate,
    input  wire          trigger,
    // Sample path.
    input  wire [DW-1:0] raw_x,
    input  wire [DW-1:0] raw_y,
    input  wire [DW-1:0] raw_z,
    input  wire [DW-1:0] hpf_x,
    input  wire [DW-1:0] hpf_y,
    input  wire [DW-1:0] hpf_z,
    // Status outputs.
    output reg           overflow,
    output wire          watermark,
    output reg  [5:0]    sample_count,
    output reg           gate_error,
    output wire [1:0]    range_select,
    output wire          hpf_out
);
    // ==========================================================
    // Configuration registers
    // ==========================================================
    reg [7:0] sample_buffer_setup;
    reg [7:0] accel_output_config;
    wire [1:0] mode   = sample_buffer_setup[`MODE_HI:`MODE_LO];
    wire [5:0] wmrk   = sample_buffer_setup[`WMRK_HI:`WMRK_LO];
    wire       buf_on = (mode != `MODE_OFF);

    assign range_select = accel_output_config[`RANGE_HI:`RANGE_LO];
    assign hpf_out      = accel_output_config[`HPF_OUT_BIT];

    // Register writes; the watermark field holds its value while active.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sample_buffer_setup <= `BUF_SETUP_RESET;
            accel_output_config <= `OUT_CFG_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_BUF_SETUP) begin
                sample_buffer_setup[`MODE_HI:`MODE_LO] <= reg_wdata[`MODE_HI:`MODE_LO];
                if (!active)
                    sample_buffer_setup[`WMRK_HI:`WMRK_LO] <= reg_wdata[`WMRK_HI:`WMRK_LO];
            end
            if (reg_addr == `ADDR_OUT_CFG)
                accel_output_config <= reg_wdata;
        end
    end

    // ==========================================================
    // Sample rate and flush causes
    // ==========================================================
    wire tick;
    reg  active_q;
    reg  sleeping_q;

    odr_tick #(.CW(CW)) u_tick (
        .ref_clk (ref_clk),
        .rst     (rst),
        .period  (sleeping ? sleep_output_rate : active_output_rate),
        .tick    (tick)
    );

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            active_q   <= 1'b0;
            sleeping_q <= 1'b0;
        end else begin
            active_q   <= active;
            sleeping_q <= sleeping;
        end
    end

    wire wr_off   = reg_wr && (reg_addr == `ADDR_BUF_SETUP) &&
                    (reg_wdata[`MODE_HI:`MODE_LO] == `MODE_OFF);
    wire rate_chg = (sleeping != sleeping_q) && !(sleep_hold_gate && sleeping);
    wire flush    = !buf_on || wr_off || rate_chg || (active && !active_q);

    // ==========================================================
    // Filter selection
    // ==========================================================
    // The filtered or raw set is chosen at capture time.
    wire [DW-1:0] sel_x = hpf_out ? hpf_x : raw_x;
    wire [DW-1:0] sel_y = hpf_out ? hpf_y : raw_y;
    wire [DW-1:0] sel_z = hpf_out ? hpf_z : raw_z;

    // ==========================================================
    // Storage and pointers
    // ==========================================================
    reg [3*DW-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]   rd_ptr;
    reg [AW-1:0]   wr_ptr;
    reg            triggered;
    reg [1:0]      axis;
    reg [3*DW-1:0] cur;

    localparam [5:0] DEPTH_CNT = DEPTH;
    localparam [5:0] DEPTH_M1  = DEPTH - 1;

    wire full     = (sample_count == DEPTH_CNT);
    wire is_empty = (sample_count == 6'h00);
    wire pop_rd   = reg_rd && buf_on && (reg_addr == `ADDR_OUT_X_HI) && (axis == 2'h0)
                    && !is_empty;
    // Overwrite always in circular mode, and in trigger mode while not triggered.
    wire overwrite = (mode == `MODE_CIRC) ||
                     ((mode == `MODE_TRIG) && !triggered);
    wire gated    = gate_error;
    // Acceptance does not depend on the watermark.
    wire push     = tick && buf_on && !gated && (!full || overwrite);
    wire drop_old = push && full;

    always @(posedge ref_clk) begin
        if (push)
            mem[wr_ptr] <= {sel_x, sel_y, sel_z};
    end

    // Count, pointers and flags.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_ptr       <= {AW{1'b0}};
            wr_ptr       <= {AW{1'b0}};
            sample_count <= 6'h00;
            overflow     <= 1'b0;
            triggered    <= 1'b0;
        end else if (flush) begin
            rd_ptr       <= {AW{1'b0}};
            wr_ptr       <= {AW{1'b0}};
            sample_count <= 6'h00;
            overflow     <= 1'b0;
            triggered    <= 1'b0;
        end else begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            // A pop and an overwrite in one cycle both move the head.
            rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, pop_rd} + {{(AW-1){1'b0}}, drop_old};
            if (push && !full && !pop_rd)
                sample_count <= sample_count + 6'h01;
            else if (pop_rd && !(push && !full))
                sample_count <= sample_count - 6'h01;
            if (full || (push && !pop_rd && sample_count == DEPTH_M1))
                overflow <= 1'b1;
            // Only the first pulse after a flush matters.
            if (trigger && mode == `MODE_TRIG)
                triggered <= 1'b1;
        end
    end

    // Watermark is a level; zero disables it. Trigger mode uses wmrk for this flag as well.
    assign watermark = (wmrk != 6'h00) && (sample_count >= wmrk);

    // Sleep gate error holds until the host empties the buffer.
    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            gate_error <= 1'b0;
        else if (!buf_on || (gate_error && is_empty))
            gate_error <= 1'b0;
        else if (sleep_hold_gate && sleeping && !sleeping_q)
            gate_error <= 1'b1;
    end

    // ==========================================================
    // Read data path
    // ==========================================================
    // Axis position within a burst; a burst end resets to the next X.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            axis <= 2'h0;
            cur  <= {3*DW{1'b0}};
        end else if (burst_end || flush) begin
            axis <= 2'h0;
        end else if (pop_rd) begin
            cur  <= mem[rd_ptr];
            axis <= 2'h1;
        end else if (reg_rd && axis != 2'h0) begin
            axis <= (axis == 2'h2) ? 2'h0 : axis + 2'h1;
        end
    end

    // Register reads; data registers follow only the X high byte when buffered.
    always @(posedge ref_clk or posedge rst) begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd) begin
            case (reg_addr)
                `ADDR_BUF_SETUP: reg_rdata <= sample_buffer_setup;
                `ADDR_OUT_CFG:   reg_rdata <= accel_output_config;
                `ADDR_OUT_X_HI: begin
                    if (!buf_on)
                        reg_rdata <= sel_x[DW-1:DW-8];
                    else if (axis == 2'h0)
                        reg_rdata <= is_empty ? 8'h00 : mem[rd_ptr][3*DW-1:3*DW-8];
                    else if (axis == 2'h1)
                        reg_rdata <= cur[2*DW-1:2*DW-8];
                    else
                        reg_rdata <= cur[DW-1:DW-8];
                end
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule

// *** rtl/accel_fifo_defines.vh ***
// Register offsets, field positions, reset values and mode codes for the sample buffer.
// Assumes inclusion by bare name from the design files.
`ifndef ACCEL_FIFO_DEFINES_VH
`define ACCEL_FIFO_DEFINES_VH
`define ADDR_OUT_X_HI      8'h01
`define ADDR_OUT_Z_LO      8'h06
`define ADDR_BUF_SETUP     8'h09
`define ADDR_OUT_CFG       8'h0e
`define BUF_SETUP_RESET    8'h00
`define OUT_CFG_RESET      8'h00
`define MODE_HI            7
`define MODE_LO            6
`define WMRK_HI            5
`define WMRK_LO            0
`define HPF_OUT_BIT        4
`define RANGE_HI           1
`define RANGE_LO           0
`define MODE_OFF           2'h0
`define MODE_CIRC          2'h1
`define MODE_STOP          2'h2
`define MODE_TRIG          2'h3
`define RANGE_2G           2'h0
`define RANGE_4G           2'h1
`define RANGE_8G           2'h2
`define RANGE_RSVD         2'h3
`define BUF_DEPTH          32
`endif

// *** rtl/odr_tick.v ***
// Output-data-rate divider producing a one-cycle sample enable.
// Assumes the rate code comes from registers on the same clock.
`timescale 1ns/10ps
module odr_tick #(
    parameter CW = 20
) (
    input  wire          ref_clk,
    input  wire          rst,
    input  wire [CW-1:0] period,
    output reg           tick
);
    reg [CW-1:0] cnt;

    // Free-running count; a period of zero is treated as one cycle.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt  <= {CW{1'b0}};
            tick <= 1'b0;
        end else if (cnt + 1'b1 >= period) begin
            cnt  <= {CW{1'b0}};
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule

// *** tb/fifo_chk_sva.sv ***
// Concurrent checks on the sample buffer ports.
// Assumes it is bound to accel_sample_fifo and clocked by ref_clk.
`timescale 1ns/10ps
module fifo_chk #(
    parameter DEPTH = 32
) (
    input wire       ref_clk,
    input wire       rst,
    input wire [7:0] reg_addr,
    input wire       reg_wr,
    input wire [7:0] reg_wdata,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    input wire       active,
    input wire       sleeping,
    input wire       overflow,
    input wire       watermark,
    input wire [5:0] sample_count,
    input wire [1:0] range_select,
    input wire       hpf_out
);
// ==========================================================
// Shadow of the setup register.
reg  [1:0] mode;
reg  [5:0] wm;
wire       cfg_wr = reg_wr && reg_addr == 8'h09;
// The level field only moves in standby, so the shadow ignores it while active.
always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
        mode <= 2'h0;
        wm   <= 6'h0;
    end else if (cfg_wr) begin
        mode <= reg_wdata[7:6];
        if (!active) begin
            wm <= reg_wdata[5:0];
        end
    end
end
default clocking cb @(posedge ref_clk); endclocking
default disable iff (rst);
// ==========================================================
// Assertions and covers.
a_range_field: assert property (reg_wr && reg_addr == 8'h0e |=>
    range_select == $past(reg_wdata[1:0])) else $error("range field wrong");
a_hpf_field: assert property (reg_wr && reg_addr == 8'h0e |=>
    hpf_out == $past(reg_wdata[4])) else $error("filter select wrong");
a_level_flag: assert property (mode != 2'h3 |->
    watermark == (wm != 6'h0 && sample_count >= wm)) else $error("level flag wrong");
a_full_overflow: assert property (sample_count == DEPTH |-> overflow)
    else $error("full without overflow");
a_count_bound: assert property (sample_count <= DEPTH)
    else $error("count above depth");
a_off_clear: assert property (cfg_wr && reg_wdata[7:6] == 2'h0 |=>
    !overflow && !watermark) else $error("flags kept after off");
a_off_empty: assert property (mode == 2'h0 |-> sample_count == 6'h00)
    else $error("count while off");
a_count_step: assert property (sample_count > $past(sample_count) |->
    sample_count == $past(sample_count) + 6'h01) else $error("count jumped");
a_stop_hold: assert property (mode == 2'h2 && sample_count == DEPTH && !reg_rd
    && !cfg_wr |=> sample_count == DEPTH || $changed(active) || $changed(sleeping))
    else $error("stop mode lost a sample");
a_axis_zero: assert property (reg_rd && reg_addr == 8'h02 && mode != 2'h0 |=>
    reg_rdata == 8'h00) else $error("direct axis read not zero");
c_overflow: cover property (overflow);
c_level: cover property (watermark);
c_trig_full: cover property (mode == 2'h3 && sample_count == DEPTH);
endmodule
bind accel_sample_fifo fifo_chk #(.DEPTH(DEPTH)) u_fifo_chk (.ref_clk(ref_clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .active(active), .sleeping(sleeping),
    .overflow(overflow), .watermark(watermark), .sample_count(sample_count),
    .range_select(range_select), .hpf_out(hpf_out));

// *** tb/host_bus.sv ***
// Host side of the register port: write, read and burst-end cycles.
// Assumes the design takes strobes on the rising edge of ref_clk.
`timescale 1ns/10ps
module host_bus (
    input  wire       ref_clk,
    input  wire [7:0] reg_rdata,
    output reg  [7:0] reg_addr,
    output reg        reg_wr,
    output reg  [7:0] reg_wdata,
    output reg        reg_rd,
    output reg        burst_end
);
// ==========================================================
// Strobes change at the falling edge, away from the sampling edge.
initial begin
    {reg_addr, reg_wr, reg_wdata, reg_rd, burst_end} = 19'h0;
end
task wr(input [7:0] a, input [7:0] d);
    begin
        @(negedge ref_clk);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge ref_clk);
        reg_wr = 1'b0;
    end
endtask
// Data is registered, so it is picked up one falling edge after the strobe.
task rd(input [7:0] a, output [7:0] d);
    begin
        @(negedge ref_clk);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge ref_clk);
        reg_rd = 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
    end
endtask
// A short burst leaves the rest of the sample unread.
task end_burst;
    begin
        @(negedge ref_clk);
        burst_end = 1'b1;
        @(negedge ref_clk);
        burst_end = 1'b0;
    end
endtask
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the sample buffer.
// Assumes host_bus as the register master and a counter as the sample source.
`timescale 1ns/10ps
module tb;
// ==========================================================
// Stimulus state.
reg         ref_clk = 1'b0;
reg         rst     = 1'b1;
reg         active  = 1'b0;
reg         sleeping = 1'b0;
reg         trigger = 1'b0;
reg  [19:0] rate    = 20'd20;
reg  [19:0] srate   = 20'hfffff;
reg  [7:0]  cnt     = 8'h00;
reg  [7:0]  d;
reg  [7:0]  a;
reg  [2:0]  i;
integer     fail_count = 0;
integer     comparisons = 0;
wire [7:0]  reg_addr, reg_wdata, reg_rdata;
wire        reg_wr, reg_rd, burst_end, overflow, watermark, hpf_out;
wire [5:0]  sample_count;
wire [1:0]  range_select;
always #25 ref_clk = ~ref_clk;
// Each raw axis differs, so a slip between axes or samples shows in the bytes.
always @(negedge ref_clk) cnt <= cnt + 8'h01;
host_bus u_host_bus (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .burst_end(burst_end));
accel_sample_fifo u_accel_sample_fifo (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .burst_end(burst_end), .reg_rdata(reg_rdata), .active(active), .sleeping(sleeping),
    .sleep_hold_gate(1'b0), .active_output_rate(rate), .sleep_output_rate(srate),
    .trigger(trigger), .raw_x({cnt, 6'h0}), .raw_y({cnt + 8'h01, 6'h0}),
    .raw_z({cnt + 8'h02, 6'h0}), .hpf_x({~cnt, 6'h0}), .hpf_y({cnt, 6'h3}),
    .hpf_z({cnt, 6'h5}), .overflow(overflow), .watermark(watermark),
    .sample_count(sample_count), .gate_error(), .range_select(range_select),
    .hpf_out(hpf_out));
task chk(input string n, input [7:0] e, input [7:0] g);
    begin
        comparisons = comparisons + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    end
endtask
task stop_test;
    begin
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    end
endtask
// ==========================================================
// Watchdog, several times the expected run.
initial begin
    #1000000;
    fail_count = fail_count + 1;
    stop_test;
end
// Main sequence.
initial begin
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    u_host_bus.rd(8'h09, d); chk("setup", 8'h00, d);
    u_host_bus.rd(8'h0e, d); chk("outcfg", 8'h00, d);
    for (i = 0; i < 4; i = i + 1) begin
        u_host_bus.wr(8'h0e, {3'h0, i[0], 2'h0, i[1:0]});
        chk("range", i[1:0], range_select);
        chk("hpf", i[0], hpf_out);
    end
    // Back to raw data, so the buffered bytes below follow the counter directly.
    u_host_bus.wr(8'h0e, 8'h00);
    chk("hpf", 8'h00, hpf_out);
    u_host_bus.rd(8'h20, d); chk("unmapped", 8'h00, d);
    u_host_bus.wr(8'h09, 8'h84);
    active = 1'b1;
    repeat (800) @(negedge ref_clk);
    chk("count", 8'd32, sample_count);
    chk("ovf", 8'h01, overflow);
    chk("wmrk", 8'h01, watermark);
    rate = 20'hfffff;
    repeat (60) @(negedge ref_clk);
    u_host_bus.rd(8'h02, d); chk("axis", 8'h00, d);
    u_host_bus.rd(8'h01, a);
    u_host_bus.rd(8'h01, d); chk("y", a + 8'h01, d);
    u_host_bus.end_burst;
    u_host_bus.rd(8'h01, d); chk("next_x", a + 8'h14, d);
    chk("count", 8'd30, sample_count);
    u_host_bus.wr(8'h09, 8'h89);
    u_host_bus.rd(8'h09, d); chk("setup", 8'h84, d);
    u_host_bus.wr(8'h09, 8'h04);
    chk("count", 8'h00, sample_count);
    chk("ovf", 8'h00, overflow);
    active = 1'b0;
    rate = 20'd20;
    u_host_bus.wr(8'h09, 8'h40);
    active = 1'b1;
    repeat (800) @(negedge ref_clk);
    chk("count", 8'd32, sample_count);
    chk("wmrk", 8'h00, watermark);
    sleeping = 1'b1;
    repeat (200) @(negedge ref_clk);
    chk("count", 8'h00, sample_count);
    sleeping = 1'b0;
    u_host_bus.wr(8'h09, 8'h00);
    u_host_bus.wr(8'h09, 8'hc0);
    trigger = 1'b1;
    @(negedge ref_clk);
    trigger = 1'b0;
    repeat (800) @(negedge ref_clk);
    chk("count", 8'd32, sample_count);
    stop_test;
end
endmodule
